/* logic/sram_pkg.sv */
`default_nettype none
package sram_pkg;
	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 19;
	localparam int DATA_W = 36;
	localparam int BYTES = 4;
	localparam int BYTE_W = 9;
	localparam int LO_W = 2;
	localparam int HI_W = ADDR_W - LO_W;
	localparam int MEM_WORDS = 1 << ADDR_W;
	localparam int WR_W = ADDR_W + DATA_W + BYTES;
	localparam int FIFO_DEPTH = 32;

	// ----------------------------------------------------------------
	// encodings and reset values
	// ----------------------------------------------------------------
	localparam logic MODE_LINEAR = 1'h0;
	localparam logic MODE_INTERLEAVED = 1'h1;
	localparam logic [BYTES-1:0] ALL_BYTES = 4'hF;
	localparam logic [BYTES-1:0] NO_BYTES = 4'h0;
	localparam logic [LO_W-1:0] LO_ZERO = 2'h0;
	localparam logic [LO_W-1:0] LO_ONE = 2'h1;
	localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0;
	localparam logic [HI_W-1:0] HI_ZERO = 17'h0;

	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_READ,
		ACC_WRITE
	} acc_e;
endpackage
`default_nettype wire

/* logic/burst_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module burst_counter (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [sram_pkg::LO_W-1:0] load_lo,
	input wire logic advance,
	input wire logic linear,
	output logic [sram_pkg::LO_W-1:0] cur_lo,
	output logic [sram_pkg::LO_W-1:0] nxt_lo
);
	typedef struct packed {
		logic [sram_pkg::LO_W-1:0] base;
		logic [sram_pkg::LO_W-1:0] beat;
	} ctr_s;

	ctr_s q_q;
	ctr_s q_d;

	// ----------------------------------------------------------------
	// sequence decode
	// ----------------------------------------------------------------
	function automatic logic [sram_pkg::LO_W-1:0] seq_lo(
		input logic [sram_pkg::LO_W-1:0] base,
		input logic [sram_pkg::LO_W-1:0] beat,
		input logic lin
	);
		if (lin) begin
			return sram_pkg::LO_W'(base + beat);
		end
		return base ^ beat;
	endfunction

	assign cur_lo = seq_lo(q_q.base, q_q.beat, linear);
	assign nxt_lo = seq_lo(q_q.base, sram_pkg::LO_W'(q_q.beat + sram_pkg::LO_ONE), linear);

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	always_comb begin
		q_d = q_q;
		if (rst) begin
			q_d.base = sram_pkg::LO_ZERO;
			q_d.beat = sram_pkg::LO_ZERO;
		end else if (load) begin
			q_d.base = load_lo;
			q_d.beat = sram_pkg::LO_ZERO;
		end else if (advance) begin
			q_d.beat = sram_pkg::LO_W'(q_q.beat + sram_pkg::LO_ONE);
		end
	end

	always_ff @(posedge clk) begin
		q_q <= q_d;
	end
endmodule
`default_nettype wire

/* logic/word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} ptr_s;

	ptr_s p_q;
	ptr_s p_d;
	logic [WIDTH-1:0] store [DEPTH];
	logic push;
	logic pop;

	// ----------------------------------------------------------------
	// flags
	// ----------------------------------------------------------------
	assign in_ready = !((p_q.wr[AW] != p_q.rd[AW]) && (p_q.wr[AW-1:0] == p_q.rd[AW-1:0]));
	assign out_valid = (p_q.wr != p_q.rd);
	assign out_data = store[p_q.rd[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// ----------------------------------------------------------------
	// pointers and storage
	// ----------------------------------------------------------------
	always_comb begin
		p_d = p_q;
		if (rst) begin
			p_d.wr = '0;
			p_d.rd = '0;
		end else begin
			if (push) begin
				p_d.wr = (AW+1)'(p_q.wr + 1'h1);
			end
			if (pop) begin
				p_d.rd = (AW+1)'(p_q.rd + 1'h1);
			end
		end
	end

	always_ff @(posedge clk) begin
		p_q <= p_d;
	end

	always_ff @(posedge clk) begin
		if (push) begin
			store[p_q.wr[AW-1:0]] <= in_data;
		end
	end
endmodule
`default_nettype wire

/* logic/pipelined_burst_sram_access.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - strap low linear, high interleaved, held static
// - inputs registered, read data via output register
// - read on strobe, all selects, writes idle
// - read word drives after next clock edge
// - first cycle after selection stays tri-stated
// - deselect with strobe tri-states outputs immediately
// - back-to-back single reads without idle cycles
// - processor strobe loads address, ignores writes, advance
// - processor-strobe write lands on second rise
// - byte write touches only selected bytes
// - global write stores all four bytes
// - write cycle turns data drivers off
// - controller-strobe write completes in one cycle
// - controller strobe loads address, ignores advance
// - two-bit wrap counter loaded from low address
// - advance low steps counter, reads and writes
// - burst writes use counter address each beat
// - interleaved order xors start with beat
// - linear order counts upward modulo four
// - both strobes low, processor strobe wins unless primary select high
module pipelined_burst_sram_access (
	input wire logic clk,
	input wire logic rst,
	input wire logic [sram_pkg::ADDR_W-1:0] addr,
	input wire logic chip_sel_primary_n,
	input wire logic chip_sel_expand_hi,
	input wire logic chip_sel_expand_lo_n,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic global_write_n,
	input wire logic byte_write_enable_n,
	input wire logic [sram_pkg::BYTES-1:0] byte_select_n,
	input wire logic output_enable_n,
	input wire logic burst_mode,
	input wire logic [sram_pkg::DATA_W-1:0] dq_in,
	output logic [sram_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe_n
);
	typedef struct packed {
		logic mode;
		logic active;
		sram_pkg::acc_e acc;
		logic show;
		logic first;
		logic [sram_pkg::DATA_W-1:0] dout;
		logic [sram_pkg::HI_W-1:0] hi;
	} core_s;

	core_s s_q;
	core_s s_d;
	logic [sram_pkg::DATA_W-1:0] mem [sram_pkg::MEM_WORDS];

	logic sel;
	logic processor_addr_strobe_n_go;
	logic controller_addr_strobe_n_go;
	logic start;
	logic open_now;
	logic desel;
	logic cont;
	logic step;
	logic [sram_pkg::BYTES-1:0] wmask;
	logic wr_req;
	logic wr_now;
	logic rd_now;
	logic [sram_pkg::LO_W-1:0] cur_lo;
	logic [sram_pkg::LO_W-1:0] nxt_lo;
	logic [sram_pkg::LO_W-1:0] use_lo;
	logic [sram_pkg::HI_W-1:0] use_hi;
	logic [sram_pkg::ADDR_W-1:0] wr_addr;
	logic [sram_pkg::ADDR_W-1:0] rd_addr;
	logic push_ready;
	logic head_valid;
	logic drain;
	logic [sram_pkg::WR_W-1:0] head;
	logic [sram_pkg::ADDR_W-1:0] head_addr;
	logic [sram_pkg::DATA_W-1:0] head_data;
	logic [sram_pkg::BYTES-1:0] head_mask;
	logic head_hit;
	logic [sram_pkg::DATA_W-1:0] rd_word;
	logic [sram_pkg::DATA_W-1:0] fwd_word;
	logic [sram_pkg::DATA_W-1:0] head_old;
	logic [sram_pkg::DATA_W-1:0] merge_word;

	// ----------------------------------------------------------------
	// cycle decode at the clock rise
	// ----------------------------------------------------------------
	assign sel = !chip_sel_primary_n && chip_sel_expand_hi && !chip_sel_expand_lo_n;
	assign processor_addr_strobe_n_go = !processor_addr_strobe_n && !chip_sel_primary_n;
	assign controller_addr_strobe_n_go = !controller_addr_strobe_n && !processor_addr_strobe_n_go;
	assign start = processor_addr_strobe_n_go || controller_addr_strobe_n_go;
	assign open_now = start && sel;
	assign desel = start && !sel;
	assign cont = !start && s_q.active;
	assign step = cont && !burst_advance_n;

	always_comb begin
		if (!global_write_n) begin
			wmask = sram_pkg::ALL_BYTES;
		end else if (!byte_write_enable_n) begin
			wmask = ~byte_select_n;
		end else begin
			wmask = sram_pkg::NO_BYTES;
		end
	end

	assign wr_req = |wmask;
	// processor-strobe start never writes; its write comes on the next rise
	assign wr_now = (controller_addr_strobe_n_go && sel && wr_req) || (cont && wr_req);
	assign rd_now = (processor_addr_strobe_n_go && sel) || (controller_addr_strobe_n_go && sel && !wr_req) || (cont && !wr_req);

	// ----------------------------------------------------------------
	// burst address
	// ----------------------------------------------------------------
	burst_counter u_ctr (
		.clk(clk),
		.rst(rst),
		.load(open_now),
		.load_lo(addr[sram_pkg::LO_W-1:0]),
		.advance(step),
		.linear(s_q.mode == sram_pkg::MODE_LINEAR),
		.cur_lo(cur_lo),
		.nxt_lo(nxt_lo)
	);

	always_comb begin
		if (open_now) begin
			use_lo = addr[sram_pkg::LO_W-1:0];
			use_hi = addr[sram_pkg::ADDR_W-1:sram_pkg::LO_W];
		end else if (step) begin
			use_lo = nxt_lo;
			use_hi = s_q.hi;
		end else begin
			use_lo = cur_lo;
			use_hi = s_q.hi;
		end
	end

	assign wr_addr = {use_hi, use_lo};
	assign rd_addr = {s_q.hi, cur_lo};

	// ----------------------------------------------------------------
	// posted writes
	// ----------------------------------------------------------------
	// the array port goes to a pending read first, so the queue drains
	// on any cycle without one; at most the head can clash with a read
	assign drain = (s_q.acc != sram_pkg::ACC_READ);

	word_fifo #(
		.WIDTH(sram_pkg::WR_W),
		.DEPTH(sram_pkg::FIFO_DEPTH)
	) u_wq (
		.clk(clk),
		.rst(rst),
		.in_valid(wr_now && !rst),
		.in_ready(push_ready),
		.in_data({wr_addr, dq_in, wmask}),
		.out_valid(head_valid),
		.out_ready(drain),
		.out_data(head)
	);

	assign head_addr = head[sram_pkg::WR_W-1 -: sram_pkg::ADDR_W];
	assign head_data = head[sram_pkg::BYTES +: sram_pkg::DATA_W];
	assign head_mask = head[sram_pkg::BYTES-1:0];
	assign head_hit = head_valid && (head_addr == rd_addr);
	assign rd_word = mem[rd_addr];
	assign head_old = mem[head_addr];

	// ----------------------------------------------------------------
	// byte lanes: array write and read forwarding
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (head_valid && drain) begin
			mem[head_addr] <= merge_word;
		end
	end

	for (genvar b = 0; b < sram_pkg::BYTES; b++) begin : g_lane
		assign merge_word[b*sram_pkg::BYTE_W +: sram_pkg::BYTE_W] = head_mask[b] ?
			head_data[b*sram_pkg::BYTE_W +: sram_pkg::BYTE_W] :
			head_old[b*sram_pkg::BYTE_W +: sram_pkg::BYTE_W];

		assign fwd_word[b*sram_pkg::BYTE_W +: sram_pkg::BYTE_W] = (head_hit && head_mask[b]) ?
			head_data[b*sram_pkg::BYTE_W +: sram_pkg::BYTE_W] :
			rd_word[b*sram_pkg::BYTE_W +: sram_pkg::BYTE_W];
	end

	// ----------------------------------------------------------------
	// control state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (rst) begin
			s_d.mode = sram_pkg::MODE_INTERLEAVED;
			s_d.active = 1'h0;
			s_d.acc = sram_pkg::ACC_IDLE;
			s_d.show = 1'h0;
			s_d.first = 1'h0;
			s_d.dout = sram_pkg::DATA_ZERO;
			s_d.hi = sram_pkg::HI_ZERO;
		end else begin
			s_d.mode = burst_mode;
			if (open_now) begin
				s_d.active = 1'h1;
			end else if (desel) begin
				s_d.active = 1'h0;
			end
			case (1'h1)
				wr_now: s_d.acc = sram_pkg::ACC_WRITE;
				rd_now: s_d.acc = sram_pkg::ACC_READ;
				default: s_d.acc = sram_pkg::ACC_IDLE;
			endcase
			s_d.hi = use_hi;
			s_d.first = open_now && !s_q.active;
			// read word lands one rise after its address; a write or a
			// deselect on that rise keeps the drivers off
			s_d.show = (s_q.acc == sram_pkg::ACC_READ) && !wr_now && !desel;
			if (s_q.acc == sram_pkg::ACC_READ) begin
				s_d.dout = fwd_word;
			end
		end
	end

	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// data pins
	// ----------------------------------------------------------------
	assign dq_out = s_q.dout;
	assign dq_oe_n = !(s_q.show && !s_q.first && !output_enable_n &&
		(s_q.acc != sram_pkg::ACC_WRITE));
endmodule
`default_nettype wire

/* dv/sram_access_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_access_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic chip_sel_primary_n,
	input wire logic chip_sel_expand_hi,
	input wire logic chip_sel_expand_lo_n,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic global_write_n,
	input wire logic byte_write_enable_n,
	input wire logic [sram_pkg::BYTES-1:0] byte_select_n,
	input wire logic output_enable_n,
	input wire logic [sram_pkg::DATA_W-1:0] dq_out,
	input wire logic dq_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// decoded cycle kinds
	// ----------------------------------------------------------------
	logic sel, p_open, c_open, desel, c_wr;
	assign sel = !chip_sel_primary_n && chip_sel_expand_hi && !chip_sel_expand_lo_n;
	assign p_open = !processor_addr_strobe_n && sel;
	assign c_open = processor_addr_strobe_n && !controller_addr_strobe_n && sel;
	assign desel = !sel && (!controller_addr_strobe_n || !processor_addr_strobe_n && !chip_sel_primary_n);
	assign c_wr = c_open && (!global_write_n || !byte_write_enable_n && !(&byte_select_n));
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	oe_high_off_a: assert property (output_enable_n |-> dq_oe_n)
		else $error("data driven with output enable high");
	write_drive_off_a: assert property (c_wr |=> dq_oe_n)
		else $error("data driven after write cycle");
	deselect_off_a: assert property (desel |=> dq_oe_n)
		else $error("data driven after deselect");
	first_mask_a: assert property (desel ##1 p_open |=> dq_oe_n)
		else $error("data driven in first selected cycle");
	read_pair_a: assert property (p_open ##1 p_open |=> output_enable_n || !dq_oe_n)
		else $error("back to back read not driven");
	write_hold_a: assert property (c_wr |=> ##1 $stable(dq_out))
		else $error("read data changed after write");
	ctrl_ignored_a: assert property ((p_open && !controller_addr_strobe_n) ##1 p_open
		|=> output_enable_n || !dq_oe_n) else $error("controller strobe not ignored");
	proc_no_write_a: assert property ((p_open && !global_write_n) ##1 p_open
		|=> output_enable_n || !dq_oe_n) else $error("write honoured on processor open");
	cover property (p_open ##1 p_open);
	cover property (c_wr);
	cover property (desel ##1 p_open);
endmodule
bind pipelined_burst_sram_access sram_access_properties i_sram_access_properties (.*);
`default_nettype wire

/* dv/sram_bus_driver.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_bus_driver (
	input wire logic clk,
	output logic [sram_pkg::ADDR_W-1:0] addr,
	output logic chip_sel_primary_n,
	output logic chip_sel_expand_hi,
	output logic chip_sel_expand_lo_n,
	output logic processor_addr_strobe_n,
	output logic controller_addr_strobe_n,
	output logic burst_advance_n,
	output logic global_write_n,
	output logic byte_write_enable_n,
	output logic [sram_pkg::BYTES-1:0] byte_select_n,
	output logic output_enable_n,
	output logic burst_mode,
	output logic [sram_pkg::DATA_W-1:0] dq_in
);
	initial begin
		addr = 19'h0;
		chip_sel_primary_n = 1'h0;
		chip_sel_expand_hi = 1'h0;
		chip_sel_expand_lo_n = 1'h0;
		processor_addr_strobe_n = 1'h1;
		controller_addr_strobe_n = 1'h1;
		burst_advance_n = 1'h1;
		global_write_n = 1'h1;
		byte_write_enable_n = 1'h1;
		byte_select_n = 4'hF;
		output_enable_n = 1'h1;
		burst_mode = sram_pkg::MODE_INTERLEAVED;
		dq_in = 36'h0;
	end
	// op = {oe_n, sel, proc_n, ctrl_n, adv_n, gw_n}
	task automatic drive(input logic [5:0] op, input logic [18:0] a, input logic [35:0] d,
		input logic [3:0] bs_n);
		@(negedge clk);
		output_enable_n = op[5];
		chip_sel_expand_hi = op[4];
		processor_addr_strobe_n = op[3];
		controller_addr_strobe_n = op[2];
		burst_advance_n = op[1];
		global_write_n = op[0];
		byte_select_n = bs_n;
		byte_write_enable_n = &bs_n;
		addr = a;
		dq_in = (!op[0] || !(&bs_n)) ? d : ~dq_in;
	endtask
	task automatic drive_ce1(input logic ce1_n, input logic [5:0] op, input logic [18:0] a);
		drive(op, a, dq_in, 4'hF);
		chip_sel_primary_n = ce1_n;
	endtask
	task automatic set_mode(input logic m);
		drive(6'h3F, addr, dq_in, 4'hF);
		burst_mode = m;
	endtask
endmodule
`default_nettype wire

/* dv/pipelined_burst_sram_access_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_access_tb_top;
	logic clk, rst, chip_sel_primary_n, chip_sel_expand_hi, chip_sel_expand_lo_n;
	logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, global_write_n;
	logic byte_write_enable_n, output_enable_n, burst_mode, dq_oe_n;
	logic [18:0] addr;
	logic [3:0] byte_select_n;
	logic [35:0] dq_in, dq_out;
	logic [35:0] mem [4];
	int n_fail = 0;
	int tests_run = 0;
	localparam logic [5:0] PRD = 6'h17, HOLD = 6'h1F, ADVR = 6'h1D, DSEL = 6'h0B, BOTH = 6'h10;
	localparam logic [5:0] CWR = 6'h3A, CWRB = 6'h3B, HWR = 6'h3E, ADVW = 6'h3C, CWR0 = 6'h1A;
	localparam logic [5:0] CRD = 6'h1B;
	localparam logic [18:0] X = 19'h00100, Y = 19'h00104, BASE = 19'h00200;
	localparam logic [35:0] D1 = 36'h123456789, D2 = 36'h987654321, D3 = 36'h5A5A5A5A5;
	localparam logic [35:0] D4 = 36'hC3C3C3C3C;
	localparam logic [3:0] BSN = 4'hA;
	pipelined_burst_sram_access i_pipelined_burst_sram_access (.*);
	sram_bus_driver i_sram_bus_driver (.*);
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({35'h0, got}, {35'h0, exp});
	endtask
	task automatic bus(input logic [5:0] op, input logic [18:0] a, input logic [35:0] d = 36'h0,
		input logic [3:0] bs_n = 4'hF);
		i_sram_bus_driver.drive(op, a, d, bs_n);
		#1;
	endtask
	function automatic logic [1:0] lo_of(input logic m, input logic [1:0] b, input int k);
		return m ? b ^ 2'(k) : b + 2'(k);
	endfunction
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_select();
		logic [35:0] ey;
		for (int i = 0; i < 4; i++) ey[9*i +: 9] = BSN[i] ? D2[9*i +: 9] : D3[9*i +: 9];
		bus(CWR, X, D1);
		bus(BOTH, Y, D3, 4'h0);
		bus(PRD, Y);
		bus(HWR, Y, D2);
		bus(CWRB, Y, D3, BSN);
		bus(DSEL, X);
		bus(PRD, X);
		bus(HOLD, X);
		chk_bit(dq_oe_n, 1'h1);
		bus(DSEL, X);
		chk_word(dq_out, D1);
		chk_bit(dq_oe_n, 1'h0);
		bus(PRD, Y);
		chk_bit(dq_oe_n, 1'h1);
		bus(CWR0, X, D4);
		bus(PRD, Y);
		chk_bit(dq_oe_n, 1'h1);
		chk_word(dq_out, ey);
		bus(PRD, X);
		bus(HOLD, X);
		chk_bit(dq_oe_n, 1'h0);
		bus(HOLD, X);
		chk_word(dq_out, D4);
		bus(BOTH, Y, D1, 4'h0);
		bus(PRD, Y);
		i_sram_bus_driver.drive_ce1(1'h1, PRD, X);
		#1;
		chk_word(dq_out, ey);
		chk_bit(dq_oe_n, 1'h0);
		i_sram_bus_driver.drive_ce1(1'h0, CRD, X);
		#1;
		chk_bit(dq_oe_n, 1'h0);
		bus(HOLD, X);
		bus(HOLD, X);
		chk_word(dq_out, D4);
		$display("select test done");
	endtask
	task automatic burst_wr(input logic m, input logic [1:0] b, input logic [35:0] d);
		i_sram_bus_driver.set_mode(m);
		for (int k = 0; k < 4; k++) begin
			bus(k != 0 ? ADVW : CWR, BASE | 19'(b), d + 36'(k));
			mem[lo_of(m, b, k)] = d + 36'(k);
		end
	endtask
	task automatic burst_rd(input logic m, input logic [1:0] b);
		i_sram_bus_driver.set_mode(m);
		for (int k = 0; k < 6; k++) begin
			bus(k == 0 ? PRD : k < 4 ? ADVR : HOLD, BASE | 19'(b));
			if (k > 1) begin
				chk_word(dq_out, mem[lo_of(m, b, k - 2)]);
				chk_bit(dq_oe_n, 1'h0);
			end
		end
	endtask
	task automatic t_burst();
		burst_wr(sram_pkg::MODE_LINEAR, 2'h2, 36'hA00000000);
		burst_rd(sram_pkg::MODE_INTERLEAVED, 2'h1);
		burst_wr(sram_pkg::MODE_INTERLEAVED, 2'h1, 36'hB00000000);
		burst_rd(sram_pkg::MODE_LINEAR, 2'h2);
		$display("burst test done");
	endtask
	initial begin
		rst = 1'h1;
		repeat (20) @(posedge clk);
		@(negedge clk) rst = 1'h0;
		t_select();
		t_burst();
		print_verdict();
	end
	initial begin
		repeat (2000) @(posedge clk);
		n_fail++;
		$display("watchdog expired");
		print_verdict();
	end
endmodule
`default_nettype wire
